/* File: common/irlc_pkg.sv */
package irlc_pkg;
   // ---------------------------------------------------------------
   // Status byte layout
   // ---------------------------------------------------------------
   localparam int STB_BUSY_BIT  = 4;
   localparam int STB_ERR_BIT   = 5;
   localparam int STB_RQS_BIT   = 6;
   localparam logic [3:0] CODE_NONE    = 4'h0;
   localparam logic [3:0] CODE_CMD_ERR = 4'h1;
   localparam logic [3:0] CODE_EXE_ERR = 4'h2;
   localparam logic [3:0] CODE_PWR_ON  = 4'h1;

   // Interface messages, decoded one per cycle
   typedef enum logic [3:0] {
      IRLC_MSG_NONE = 4'h0,
      IRLC_MSG_MLA  = 4'h1,
      IRLC_MSG_MTA  = 4'h2,
      IRLC_MSG_GTL  = 4'h3,
      IRLC_MSG_LLO  = 4'h4,
      IRLC_MSG_UNL  = 4'h5,
      IRLC_MSG_UNT  = 4'h6,
      IRLC_MSG_DCL  = 4'h7,
      IRLC_MSG_SDC  = 4'h8,
      IRLC_MSG_SPE  = 4'h9,
      IRLC_MSG_SPD  = 4'ha
   } irlc_msg_t;

   // Message strobe with its code
   typedef struct packed {
      logic      valid;
      irlc_msg_t code;
   } irlc_msg_req_t;

   // Pending event set
   typedef struct packed {
      logic pwr_on;
      logic cmd_err;
      logic exe_err;
   } irlc_evt_t;
endpackage : irlc_pkg

/* File: rtl/irlc_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for bus lines
module irlc_sync
   import irlc_pkg::*;
#(
   parameter int W = 2
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // ------------------------------------------------------------
   // First stage feeds only the second
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : irlc_sync

/* File: rtl/irlc_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - Local state: only interface messages run; device commands raise an error event.
// - Remote state: addressed commands execute and the panel update strobe fires.
// - Manual panel change while remote returns the device to local.
// - While a waveform is sent, transfer lamp lit and acquisitions blocked.
// - No local lockout; LLO raises an error event instead.
// - REN plus own listen address: go remote, light addressed lamp.
// - REN false forces local and holds it there.
// - A REN-driven drop to local never aborts the command executing.
// - GTL sends a listen-addressed device to local, execution untouched.
// - UNL idles the listener; no commands accepted while idle.
// - UNT idles the talker; no data sent while idle.
// - IFC idles talker and listener and turns the addressed lamp off.
// - DCL discards pending input, output and unexecuted settings.
// - DCL clears all events but power-on; SRQ stays only for power-on.
// - SDC clears like DCL, only when listen-addressed.
// - SPE: talker sends status byte; SPD: back to normal output.
// - SRQ asserted at every power-on.
// - Serial variant supplies the same messages as coded strobes.
// - Status bit 4 set while a command executes.
// - SRQ reasserted until every event reported; each cleared on poll read.
module irlc_ctrl
   import irlc_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   input  wire logic          ren_pin,
   input  wire logic          ifc_pin,
   input  wire irlc_msg_req_t msg_req,
   input  wire logic          serial_mode,
   input  wire logic          cmd_valid,
   input  wire logic          cmd_done,
   input  wire logic          panel_change,
   input  wire logic          wave_busy,
   input  wire logic          talk_data_valid,
   input  wire logic [7:0]    talk_data,
   input  wire logic          stb_read,
   input  wire logic          rqs_on,
   output logic               cmd_accept,
   output logic               panel_update,
   output logic               bus_controlled_state,
   output logic               addr_lamp,
   output logic               xfer_lamp,
   output logic               acq_block,
   output logic               listen_active,
   output logic               talk_active,
   output logic               flush,
   output logic               srq,
   output logic               out_valid,
   output logic [7:0]         out_data,
   output logic               cmd_busy
);
   // -------------------------------------------------------------
   // Line synchronisers (serial variant has no hardware lines)
   // -------------------------------------------------------------
   logic [1:0] lines_s;
   logic       ren_s;
   logic       ifc_s;

   irlc_sync #(.W(2)) u_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .d       ({ren_pin, ifc_pin}),
      .q       (lines_s)
   );

   // Serial variant: REN taken as asserted; GTL strobe drops remote
   assign ren_s = lines_s[1] | serial_mode;
   assign ifc_s = lines_s[0] & ~serial_mode;

   // -------------------------------------------------------------
   // Message decode
   // -------------------------------------------------------------
   logic m_mla, m_mta, m_gtl, m_llo, m_unl, m_unt;
   logic m_dcl, m_sdc, m_spe, m_spd, dev_clear;

   assign m_mla = msg_req.valid && msg_req.code == IRLC_MSG_MLA;
   assign m_mta = msg_req.valid && msg_req.code == IRLC_MSG_MTA;
   assign m_gtl = msg_req.valid && msg_req.code == IRLC_MSG_GTL;
   assign m_llo = msg_req.valid && msg_req.code == IRLC_MSG_LLO;
   assign m_unl = msg_req.valid && msg_req.code == IRLC_MSG_UNL;
   assign m_unt = msg_req.valid && msg_req.code == IRLC_MSG_UNT;
   assign m_dcl = msg_req.valid && msg_req.code == IRLC_MSG_DCL;
   assign m_sdc = msg_req.valid && msg_req.code == IRLC_MSG_SDC;
   assign m_spe = msg_req.valid && msg_req.code == IRLC_MSG_SPE;
   assign m_spd = msg_req.valid && msg_req.code == IRLC_MSG_SPD;

   assign dev_clear = m_dcl || (m_sdc && listen_active);

   // -------------------------------------------------------------
   // Listen and talk functions
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         listen_active <= 1'b0;
      end else if (ifc_s || m_unl) begin
         listen_active <= 1'b0;
      end else if (m_mla) begin
         listen_active <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         talk_active <= 1'b0;
      end else if (ifc_s || m_unt) begin
         talk_active <= 1'b0;
      end else if (m_mta) begin
         talk_active <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Local / remote state
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         bus_controlled_state <= 1'b0;
      end else if (!ren_s) begin
         bus_controlled_state <= 1'b0;
      end else if (panel_change && bus_controlled_state) begin
         bus_controlled_state <= 1'b0;
      end else if (m_gtl && listen_active) begin
         bus_controlled_state <= 1'b0;
      end else if (m_mla) begin
         bus_controlled_state <= 1'b1;
      end
   end

   // Lamp follows remote; IFC forces it dark
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         addr_lamp <= 1'b0;
      end else if (ifc_s || !ren_s) begin
         addr_lamp <= 1'b0;
      end else if (m_mla) begin
         addr_lamp <= 1'b1;
      end else if (!bus_controlled_state) begin
         addr_lamp <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Command execution; busy is independent of remote so a drop
   // to local never aborts the running command
   // -------------------------------------------------------------
   logic cmd_take;
   logic cmd_reject;

   assign cmd_take   = cmd_valid && !cmd_busy && listen_active
                       && bus_controlled_state && !dev_clear;
   assign cmd_reject = cmd_valid && !cmd_busy && listen_active
                       && !bus_controlled_state;
   assign cmd_accept = cmd_take;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cmd_busy <= 1'b0;
      end else if (cmd_take) begin
         cmd_busy <= 1'b1;
      end else if (cmd_done) begin
         cmd_busy <= 1'b0;
      end
   end

   // Panel refresh pulse when a command completes
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         panel_update <= 1'b0;
      end else begin
         panel_update <= cmd_busy && cmd_done;
      end
   end

   // Discard queues and unexecuted settings
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         flush <= 1'b0;
      end else begin
         flush <= dev_clear;
      end
   end

   // -------------------------------------------------------------
   // Waveform transfer lamp and acquisition hold
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         xfer_lamp <= 1'b0;
      end else begin
         xfer_lamp <= wave_busy && talk_active;
      end
   end
   assign acq_block = xfer_lamp;

   // -------------------------------------------------------------
   // Events: set wins over clear
   // -------------------------------------------------------------
   irlc_evt_t evt_r;
   logic      poll_r;
   logic      poll_take;
   logic      rep_pwr;
   logic      rep_cmd;
   logic      rep_exe;

   assign poll_take = stb_read && poll_r && talk_active;
   // Most serious first: power-on, then execution, then command
   assign rep_pwr = poll_take && evt_r.pwr_on;
   assign rep_exe = poll_take && !evt_r.pwr_on && evt_r.exe_err;
   assign rep_cmd = poll_take && !evt_r.pwr_on && !evt_r.exe_err && evt_r.cmd_err;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         evt_r.pwr_on <= 1'b1;
      end else if (rep_pwr) begin
         evt_r.pwr_on <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         evt_r.cmd_err <= 1'b0;
      end else if (cmd_reject) begin
         evt_r.cmd_err <= 1'b1;
      end else if (dev_clear || rep_cmd) begin
         evt_r.cmd_err <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         evt_r.exe_err <= 1'b0;
      end else if (m_llo) begin
         evt_r.exe_err <= 1'b1;
      end else if (dev_clear || rep_exe) begin
         evt_r.exe_err <= 1'b0;
      end
   end

   // SRQ stays while anything pending; RQS off still lets power-on out
   assign srq = evt_r.pwr_on
                || (rqs_on && (evt_r.cmd_err || evt_r.exe_err));

   // -------------------------------------------------------------
   // Serial poll mode
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         poll_r <= 1'b0;
      end else if (m_spe) begin
         poll_r <= 1'b1;
      end else if (m_spd || ifc_s) begin
         poll_r <= 1'b0;
      end
   end

   logic [7:0] stb_nxt;

   always_comb begin
      stb_nxt = 8'h00;
      stb_nxt[STB_BUSY_BIT] = cmd_busy;
      if (evt_r.pwr_on) begin
         stb_nxt[3:0]         = CODE_PWR_ON;
         stb_nxt[STB_RQS_BIT] = 1'b1;
      end else if (evt_r.exe_err) begin
         stb_nxt[3:0]         = CODE_EXE_ERR;
         stb_nxt[STB_ERR_BIT] = 1'b1;
         stb_nxt[STB_RQS_BIT] = rqs_on;
      end else if (evt_r.cmd_err) begin
         stb_nxt[3:0]         = CODE_CMD_ERR;
         stb_nxt[STB_ERR_BIT] = 1'b1;
         stb_nxt[STB_RQS_BIT] = rqs_on;
      end else begin
         stb_nxt[3:0] = CODE_NONE;
      end
   end

   // -------------------------------------------------------------
   // Talker output: status byte in poll, data otherwise
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         out_data  <= 8'h00;
      end else if (!talk_active || dev_clear) begin
         out_valid <= 1'b0;
         out_data  <= 8'h00;
      end else if (poll_r) begin
         out_valid <= 1'b1;
         out_data  <= stb_nxt;
      end else begin
         out_valid <= talk_data_valid;
         out_data  <= talk_data;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   a_ren_low_local: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ren_s |=> !bus_controlled_state) else $error("remote while REN low");
   a_mla_goes_remote: assert property (@(posedge ref_clk) disable iff (!nrst)
      ren_s && m_mla && !panel_change && !ifc_s |=> bus_controlled_state && addr_lamp)
      else $error("listen address did not go remote");
   a_unl_idles: assert property (@(posedge ref_clk) disable iff (!nrst)
      m_unl |=> !listen_active) else $error("listener not idled");
   a_ifc_idles_all: assert property (@(posedge ref_clk) disable iff (!nrst)
      ifc_s |=> !listen_active && !talk_active && !addr_lamp)
      else $error("IFC left an active function");
   a_idle_no_data: assert property (@(posedge ref_clk) disable iff (!nrst)
      !talk_active |=> !out_valid) else $error("idle talker sent data");
   a_llo_err: assert property (@(posedge ref_clk) disable iff (!nrst)
      m_llo |=> evt_r.exe_err) else $error("LLO raised no error");
   a_dcl_keeps_pwr: assert property (@(posedge ref_clk) disable iff (!nrst)
      dev_clear && !m_llo && !cmd_reject |=> !evt_r.exe_err && !evt_r.cmd_err
      && evt_r.pwr_on == ($past(evt_r.pwr_on) && !$past(rep_pwr)))
      else $error("DCL clear wrong");
   a_busy_held: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_busy && !cmd_done |=> cmd_busy) else $error("execution aborted");
   a_local_no_take: assert property (@(posedge ref_clk) disable iff (!nrst)
      !bus_controlled_state |-> !cmd_accept) else $error("command taken in local");
   a_poll_stb: assert property (@(posedge ref_clk) disable iff (!nrst)
      poll_r && talk_active && !dev_clear |=> out_valid
      && out_data[STB_BUSY_BIT] == $past(cmd_busy)) else $error("bad status byte");
   a_xfer_block: assert property (@(posedge ref_clk) disable iff (!nrst)
      wave_busy && talk_active |=> xfer_lamp && acq_block)
      else $error("acquisition not blocked");
endmodule : irlc_ctrl

/* File: test/irlc_ctlr.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Bus controller model: REN, IFC, decoded messages and poll reads
// -----------------------------------------------------------------
module irlc_ctlr
   import irlc_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       out_valid,
   input  wire logic [7:0] out_data,
   output logic            ren_pin,
   output logic            ifc_pin,
   output irlc_msg_req_t   msg_req,
   output logic            stb_read,
   output logic            rqs_on
);
   // Time of the last strobe release, so back-to-back strobes get a gap
   time last_clr = 0;

   // Idle bus, service requests off until the address is known
   initial begin
      ren_pin = 1'b0;
      ifc_pin = 1'b0;
      msg_req = '0;
      stb_read = 1'b0;
      rqs_on = 1'b0;
   end

   // Drive just after the edge, never on it
   task tick;
      @(posedge ref_clk);
      #1;
   endtask : tick

   // One-cycle message strobe
   task send(input irlc_msg_t c);
      if ($time == last_clr) begin
         tick; // Let an edge pass rather than drive the strobe twice at once
      end
      msg_req = '{valid: 1'b1, code: c};
      tick;
      msg_req = '0;
      last_clr = $time;
   endtask : send

   // Levels cross a two-flop synchroniser, so allow a margin
   task set_ren(input logic v);
      ren_pin = v;
      repeat (4) tick;
   endtask : set_ren

   task pulse_ifc;
      ifc_pin = 1'b1;
      repeat (4) tick;
      ifc_pin = 1'b0;
   endtask : pulse_ifc

   // Address the device, only then accept service requests
   task learn_addr;
      send(IRLC_MSG_MLA);
      rqs_on = 1'b1;
   endtask : learn_addr

   // Serial poll: status byte taken before the read clears an event
   task poll(output logic [7:0] b, output logic v);
      send(IRLC_MSG_SPE);
      tick;
      b = out_data;
      v = out_valid;
      stb_read = 1'b1;
      tick;
      stb_read = 1'b0;
      send(IRLC_MSG_SPD);
   endtask : poll
endmodule : irlc_ctlr

/* File: test/irlc_ctrl_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module irlc_ctrl_test;
   import irlc_pkg::*;
   logic ref_clk = 1'b0, nrst = 1'b0, serial_mode = 1'b0, cmd_valid = 1'b0;
   logic cmd_done = 1'b0, panel_change = 1'b0, wave_busy = 1'b0;
   logic talk_data_valid = 1'b0, ren_pin, ifc_pin, stb_read, rqs_on;
   logic [7:0] talk_data = 8'h00, out_data, b;
   irlc_msg_req_t msg_req;
   logic cmd_accept, panel_update, bus_controlled_state, addr_lamp, xfer_lamp;
   logic acq_block, listen_active, talk_active, flush, srq, out_valid, cmd_busy, v;
   int errors = 0, n_checks = 0;

   // ---------------------------------------------------------------
   // Clock, device and controller
   // ---------------------------------------------------------------
   always #5 ref_clk = ~ref_clk;
   irlc_ctrl irlc_ctrl_inst (.ref_clk(ref_clk), .nrst(nrst), .ren_pin(ren_pin),
      .ifc_pin(ifc_pin), .msg_req(msg_req), .serial_mode(serial_mode),
      .cmd_valid(cmd_valid), .cmd_done(cmd_done), .panel_change(panel_change),
      .wave_busy(wave_busy), .talk_data_valid(talk_data_valid),
      .talk_data(talk_data), .stb_read(stb_read), .rqs_on(rqs_on),
      .cmd_accept(cmd_accept), .panel_update(panel_update),
      .bus_controlled_state(bus_controlled_state), .addr_lamp(addr_lamp),
      .xfer_lamp(xfer_lamp), .acq_block(acq_block), .listen_active(listen_active),
      .talk_active(talk_active), .flush(flush), .srq(srq), .out_valid(out_valid),
      .out_data(out_data), .cmd_busy(cmd_busy));
   irlc_ctlr irlc_ctlr_inst (.ref_clk(ref_clk), .out_valid(out_valid),
      .out_data(out_data), .ren_pin(ren_pin), .ifc_pin(ifc_pin),
      .msg_req(msg_req), .stb_read(stb_read), .rqs_on(rqs_on));

   task tick;
      @(posedge ref_clk);
      #1;
   endtask : tick

   task send(input irlc_msg_t c);
      irlc_ctlr_inst.send(c);
   endtask : send

   // Offer a command and look at the combinational answer
   task offer(input logic exp);
      cmd_valid = 1'b1;
      #1;
      `CHK("cmd_accept", exp, cmd_accept)
      tick;
      cmd_valid = 1'b0;
   endtask : offer

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset;
      `CHK("srq", 1'b1, srq)
      `CHK("remote", 1'b0, bus_controlled_state)
      `CHK("listen", 1'b0, listen_active)
      `CHK("talk", 1'b0, talk_active)
      `CHK("lamp", 1'b0, addr_lamp)
   endtask : t_reset

   // Address, poll away the power-on event, then plain talker data
   task t_remote_poll;
      irlc_ctlr_inst.set_ren(1'b1);
      irlc_ctlr_inst.learn_addr;
      `CHK("remote", 1'b1, bus_controlled_state)
      `CHK("lamp", 1'b1, addr_lamp)
      send(IRLC_MSG_MTA);
      irlc_ctlr_inst.poll(b, v);
      `CHK("stb", 8'h41, b)
      `CHK("stb_valid", 1'b1, v)
      `CHK("srq", 1'b0, srq)
      talk_data_valid = 1'b1;
      talk_data = 8'ha5;
      tick;
      `CHK("data", 8'ha5, out_data)
      talk_data_valid = 1'b0;
   endtask : t_remote_poll

   // Command in remote, then REN dropped while it executes
   task t_cmd;
      offer(1'b1);
      `CHK("busy", 1'b1, cmd_busy)
      irlc_ctlr_inst.set_ren(1'b0);
      `CHK("remote", 1'b0, bus_controlled_state)
      `CHK("busy", 1'b1, cmd_busy)
      send(IRLC_MSG_MLA);
      `CHK("remote", 1'b0, bus_controlled_state)
      cmd_done = 1'b1;
      tick;
      cmd_done = 1'b0;
      `CHK("busy", 1'b0, cmd_busy)
      `CHK("panel", 1'b1, panel_update)
      irlc_ctlr_inst.set_ren(1'b1);
      send(IRLC_MSG_MLA);
   endtask : t_cmd

   // Lockout refused as an error; device clear drops it again
   task t_llo_dcl;
      send(IRLC_MSG_LLO);
      tick;
      `CHK("srq", 1'b1, srq)
      irlc_ctlr_inst.poll(b, v);
      `CHK("stb", 8'h62, b)
      send(IRLC_MSG_LLO);
      tick;
      send(IRLC_MSG_DCL);
      `CHK("flush", 1'b1, flush)
      `CHK("srq", 1'b0, srq)
   endtask : t_llo_dcl

   // Go to local, refused command, selected clear and unlisten
   task t_gtl_unl;
      send(IRLC_MSG_GTL);
      `CHK("remote", 1'b0, bus_controlled_state)
      `CHK("listen", 1'b1, listen_active)
      offer(1'b0);
      tick;
      `CHK("srq", 1'b1, srq)
      send(IRLC_MSG_SDC);
      `CHK("flush", 1'b1, flush)
      `CHK("srq", 1'b0, srq)
      send(IRLC_MSG_UNL);
      `CHK("listen", 1'b0, listen_active)
      send(IRLC_MSG_SDC);
      `CHK("flush", 1'b0, flush)
      offer(1'b0);
      tick;
      `CHK("srq", 1'b0, srq)
   endtask : t_gtl_unl

   // Transfer lamp while talking, silence after untalk
   task t_talk;
      send(IRLC_MSG_MTA);
      wave_busy = 1'b1;
      repeat (2) tick;
      `CHK("xfer", 1'b1, xfer_lamp)
      `CHK("acq_blk", 1'b1, acq_block)
      wave_busy = 1'b0;
      send(IRLC_MSG_UNT);
      `CHK("talk", 1'b0, talk_active)
      `CHK("xfer", 1'b0, xfer_lamp)
      talk_data_valid = 1'b1;
      repeat (2) tick;
      `CHK("out_valid", 1'b0, out_valid)
      talk_data_valid = 1'b0;
   endtask : t_talk

   // Manual change, interface clear, serial variant
   task t_panel_ifc_serial;
      send(IRLC_MSG_MLA);
      `CHK("remote", 1'b1, bus_controlled_state)
      panel_change = 1'b1;
      tick;
      panel_change = 1'b0;
      tick;
      `CHK("remote", 1'b0, bus_controlled_state)
      send(IRLC_MSG_MLA);
      send(IRLC_MSG_MTA);
      irlc_ctlr_inst.pulse_ifc;
      `CHK("listen", 1'b0, listen_active)
      `CHK("talk", 1'b0, talk_active)
      `CHK("lamp", 1'b0, addr_lamp)
      irlc_ctlr_inst.set_ren(1'b0);
      serial_mode = 1'b1;
      send(IRLC_MSG_MLA);
      `CHK("remote", 1'b1, bus_controlled_state)
      send(IRLC_MSG_MTA);
      irlc_ctlr_inst.poll(b, v);
      `CHK("stb", 8'h00, b)
      offer(1'b1);
      cmd_done = 1'b1;
      tick;
      cmd_done = 1'b0;
      serial_mode = 1'b0;
   endtask : t_panel_ifc_serial

   // Single place where the run ends
   task test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      repeat (8) tick;
      nrst = 1'b1;
      t_reset;
      t_remote_poll;
      t_cmd;
      t_llo_dcl;
      t_gtl_unl;
      t_talk;
      t_panel_ifc_serial;
      test_done;
   end
endmodule : irlc_ctrl_test
